// ==== src/csrm_monitor.sv ====
// controlled stop ramp monitor with apb register slave
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
module csrm_monitor
	import csrm_pkg::*;
#(
	parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              pclken,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              stop_bus_bit,
	input  wire logic              param_unlock,
	input  wire logic              enc_fault,
	input  wire logic [15:0]       speed_rpm,
	input  wire logic              speed_vld,
	output logic                   torque_off,
	output logic                   pos_hold,
	output logic                   error_stop,
	output logic                   zero_speed,
	output logic                   stop_active
);

	// ====================================================================
	// state
	typedef struct packed {
		csrm_state_t st;
		logic        req_s1;
		logic        req_s2;
		logic        unl_s1;
		logic        unl_s2;
		logic        enc_s1;
		logic        enc_s2;
		logic [15:0] pre;
		logic [15:0] ms;
		logic [7:0]  enc_cnt;
		logic [15:0] spd;
		logic [15:0] start;
		logic [15:0] dly;
		logic [15:0] span;
		logic [15:0] env;
		logic [31:0] acc;
		logic [15:0] margin;
		logic        follow;
		csrm_cfg_t   cfg;
		csrm_out_t   out;
		csrm_apb_t   apb;
	} csrm_regs_t;

	localparam logic [15:0] CYC_LAST = 16'(CYC_PER_MS_P - 1);

	csrm_regs_t  s_q;
	csrm_regs_t  s_d;
	logic        tick;
	logic        req;
	logic        zero;
	logic        expired;
	logic        chk;
	logic        viol;
	logic        setup;
	logic        wr;
	logic        ack;
	logic        enc_trip;
	logic [15:0] rel_off;
	logic [15:0] offs;
	logic [16:0] start_sum;
	logic [15:0] new_start;
	logic [15:0] new_dly;
	logic [15:0] diff;
	logic [31:0] acc_n;
	logic [31:0] rd;
	logic        bad;

	// byte-lane merge of a write into a field of up to two bytes
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// ====================================================================
	// combinational evaluation, once per control cycle
	always_comb begin
		s_d = s_q;
		// the stop, unlock and encoder fault pins pass two flip-flops before use
		s_d.req_s1 = stop_bus_bit;
		s_d.req_s2 = s_q.req_s1;
		s_d.unl_s1 = param_unlock;
		s_d.unl_s2 = s_q.unl_s1;
		s_d.enc_s1 = enc_fault;
		s_d.enc_s2 = s_q.enc_s1;
		if (speed_vld) begin
			s_d.spd = speed_rpm;
		end
		zero = s_q.spd <= s_q.cfg.window;
		s_d.out.zero = zero;
		req = s_q.req_s2 & s_q.cfg.src;
		// millisecond time base
		tick = s_q.pre == CYC_LAST;
		s_d.pre = tick ? '0 : s_q.pre + 16'h0001;
		expired = s_q.ms >= s_q.cfg.interval;
		if (!s_q.enc_s2) begin
			s_d.enc_cnt = '0;
		end else if (tick && s_q.enc_cnt != 8'hFF) begin
			s_d.enc_cnt = s_q.enc_cnt + 8'h01;
		end
		enc_trip = s_q.enc_s2 && (s_q.enc_cnt >= s_q.cfg.enc_ms);

		rel_off = 16'((32'(s_q.spd) * 32'(s_q.cfg.rel)) / PCT_FULL);
		if (s_q.cfg.ofs_abs) begin
			offs = s_q.cfg.abs_ofs;
		end else if (s_q.cfg.rel == RST_REL) begin
			offs = s_q.cfg.window;
		end else begin
			offs = rel_off;
		end
		start_sum = 17'(s_q.spd) + 17'(offs);
		new_start = start_sum[16] ? MARGIN_TOP : start_sum[15:0];
		new_dly = 16'((32'(s_q.cfg.interval) * 32'(s_q.cfg.smooth)) / SMOOTH_DIV);

		chk = s_q.cfg.ramp_en && (s_q.st == CSRM_STOP) && (s_q.ms >= s_q.dly);
		viol = chk && (s_q.spd > s_q.env);
		diff = (s_q.env > s_q.spd) ? s_q.env - s_q.spd : '0;

		// ================================================================
		// apb slave, answer in the access phase
		setup = psel && !penable;
		wr = psel && penable && pwrite && s_q.apb.pready && !s_q.apb.pslverr;
		ack = wr && (paddr == OFS_CTRL) && pwdata[CTRL_ACK];
		rd = '0;
		bad = 1'b0;
		unique case (paddr)
			OFS_CTRL: begin
				rd[CTRL_FOLLOW] = s_q.follow;
			end
			OFS_STATUS: begin
				rd = {26'h0, s_q.req_s2, s_q.out};
				bad = pwrite;
			end
			OFS_ENC: begin
				rd = {24'h0, s_q.cfg.enc_ms};
				bad = pwrite && (!s_q.unl_s2 || (pwdata[7:0] != ENC_MS_SHORT
					&& pwdata[7:0] != ENC_MS_MID && pwdata[7:0] != ENC_MS_LONG));
			end
			OFS_WINDOW: begin
				rd = {16'h0, s_q.cfg.window};
				bad = pwrite && !s_q.unl_s2;
			end
			OFS_INTVL: begin
				rd = {16'h0, s_q.cfg.interval};
				bad = pwrite && !s_q.unl_s2;
			end
			OFS_CFG: begin
				rd = {28'h0, s_q.cfg.ofs_abs, s_q.cfg.ramp_en, s_q.cfg.mode, s_q.cfg.src};
				bad = pwrite && !s_q.unl_s2;
			end
			OFS_SMOOTH: begin
				rd = {24'h0, s_q.cfg.smooth};
				bad = pwrite && (!s_q.unl_s2 || pwdata[7:0] > PCT_MAX);
			end
			OFS_REL: begin
				rd = {24'h0, s_q.cfg.rel};
				bad = pwrite && (!s_q.unl_s2 || pwdata[7:0] > PCT_MAX);
			end
			OFS_ABS: begin
				rd = {16'h0, s_q.cfg.abs_ofs};
				bad = pwrite && !s_q.unl_s2;
			end
			OFS_MONSPD: begin
				rd = {16'h0, s_q.env};
				bad = pwrite;
			end
			OFS_MARGIN: begin
				rd = {16'h0, s_q.margin};
				bad = pwrite;
			end
			default: begin
				bad = 1'b1;
			end
		endcase
		s_d.apb.pready = setup;
		s_d.apb.pslverr = setup && bad;
		s_d.apb.prdata = (setup && !pwrite && !bad) ? rd : '0;

		if (wr) begin
			unique case (paddr)
				OFS_CTRL: s_d.follow = pwdata[CTRL_FOLLOW];
				OFS_ENC: s_d.cfg.enc_ms = pwdata[7:0];
				OFS_WINDOW: s_d.cfg.window = merge16(s_q.cfg.window, pwdata, pstrb);
				OFS_INTVL: s_d.cfg.interval = merge16(s_q.cfg.interval, pwdata, pstrb);
				OFS_CFG: begin
					if (pstrb[0]) begin
						s_d.cfg.src = pwdata[CFG_SRC];
						s_d.cfg.mode = pwdata[CFG_MODE];
						s_d.cfg.ramp_en = pwdata[CFG_RAMP];
						s_d.cfg.ofs_abs = pwdata[CFG_OFSABS];
					end
				end
				OFS_SMOOTH: s_d.cfg.smooth = pwdata[7:0];
				OFS_REL: s_d.cfg.rel = pwdata[7:0];
				OFS_ABS: s_d.cfg.abs_ofs = merge16(s_q.cfg.abs_ofs, pwdata, pstrb);
				default: s_d.follow = s_q.follow;
			endcase
		end

		// ================================================================
		// stop sequence
		acc_n = s_q.acc;
		unique case (s_q.st)
			CSRM_IDLE: begin
				if (req) begin
					s_d.st = CSRM_STOP;
					s_d.pre = '0;
					s_d.ms = '0;
					s_d.start = new_start;
					s_d.env = new_start;
					s_d.dly = new_dly;
					s_d.span = (s_q.cfg.interval == new_dly) ? 16'h0001
						: s_q.cfg.interval - new_dly;
					s_d.acc = '0;
					s_d.margin = MARGIN_TOP;
				end
			end
			CSRM_STOP: begin
				if (tick && !expired) begin
					s_d.ms = s_q.ms + 16'h0001;
				end
				// ramp settings preset by the controller
				if (tick && s_q.cfg.ramp_en && s_q.ms >= s_q.dly) begin
					acc_n = s_q.acc + 32'(s_q.start);
				end
				if (acc_n >= 32'(s_q.span)) begin
					acc_n = acc_n - 32'(s_q.span);
					s_d.env = (s_q.env == '0) ? '0 : s_q.env - 16'h0001;
				end
				s_d.acc = acc_n;
				if (chk && diff < s_q.margin) begin
					s_d.margin = diff;
				end
				if (viol) begin
					s_d.st = CSRM_ERROR;
				// mode 1 stops at zero speed, into hold, or into torque off with follow set
				end else if (s_q.cfg.mode && zero) begin
					s_d.st = s_q.follow ? CSRM_TOFF : CSRM_HOLD;
				end else if (expired && zero) begin
					s_d.st = s_q.follow ? CSRM_TOFF : CSRM_HOLD;
				end else if (expired) begin
					s_d.st = CSRM_ERROR;
				end
			end
			CSRM_HOLD, CSRM_TOFF: begin
				if (!req) begin
					s_d.st = CSRM_IDLE;
				end
			end
			CSRM_ERROR: begin
				if (ack && !req) begin
					s_d.st = CSRM_IDLE;
				end
			end
		endcase
		if (enc_trip) begin
			s_d.st = CSRM_ERROR;
		end

		s_d.out.active = s_d.st == CSRM_STOP;
		s_d.out.pos_hold = s_d.st == CSRM_HOLD;
		s_d.out.torque_off = (s_d.st == CSRM_TOFF) || (s_d.st == CSRM_ERROR);
		s_d.out.err = s_d.st == CSRM_ERROR;
	end

	// ====================================================================
	// state register with clock enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{st: CSRM_IDLE, pre: '0, ms: '0, enc_cnt: '0, spd: '0, start: '0,
				dly: '0, span: 16'h0001, env: '0, acc: '0, margin: MARGIN_TOP, follow: 1'b0,
				cfg: '{enc_ms: ENC_MS_SHORT, window: RST_WINDOW, interval: RST_INTVL,
					src: 1'b0, mode: 1'b0, ramp_en: 1'b0, ofs_abs: 1'b0,
					smooth: RST_SMOOTH, rel: RST_REL, abs_ofs: RST_ABS},
				out: '0, apb: '0, default: 1'b0};
		end else if (pclken) begin
			s_q <= s_d;
		end
	end

	// outputs straight from flip-flops
	assign prdata      = s_q.apb.prdata;
	assign pready      = s_q.apb.pready;
	assign pslverr     = s_q.apb.pslverr;
	assign torque_off  = s_q.out.torque_off;
	assign pos_hold    = s_q.out.pos_hold;
	assign error_stop  = s_q.out.err;
	assign zero_speed  = s_q.out.zero;
	assign stop_active = s_q.out.active;

	// ====================================================================
	// assertions
	default clocking cb @(posedge pclk iff pclken);
	endclocking
	default disable iff (!presetn);

	err_torque_a: assert property (error_stop |-> torque_off)
		else $error("error stop without torque off");
	hold_torque_a: assert property (pos_hold |-> !torque_off && !error_stop)
		else $error("hold with torque removed");
	err_sticky_a: assert property (error_stop && !ack |=> error_stop)
		else $error("error stop ended without acknowledge");
	ramp_err_a: assert property (viol && !enc_trip |=> error_stop && !pos_hold)
		else $error("envelope overrun not stopped");
	expire_err_a: assert property (s_q.st == CSRM_STOP && expired && !zero && !viol
		|=> error_stop)
		else $error("no error at interval end");
	mode_zero_a: assert property (s_q.st == CSRM_STOP && s_q.cfg.mode && zero && !viol
		&& !enc_trip && !s_q.follow |=> pos_hold)
		else $error("mode one did not hold at zero");
	mode_wait_a: assert property (s_q.st == CSRM_STOP && !s_q.cfg.mode && !expired
		|=> !pos_hold)
		else $error("hold before interval end");
	src_gate_a: assert property (!s_q.cfg.src && s_q.st == CSRM_IDLE && !enc_trip
		|=> !stop_active)
		else $error("stop started with source disabled");
	delay_chk_a: assert property (s_q.st == CSRM_STOP && s_q.ms < s_q.dly |-> !chk)
		else $error("envelope checked during delay");
	lock_cfg_a: assert property (!s_q.unl_s2 |=> $stable(s_q.cfg))
		else $error("setting changed while locked");
	zero_flag_a: assert property (speed_vld ##1 !speed_vld |=> zero_speed
		== (s_q.spd <= s_q.cfg.window))
		else $error("zero flag wrong");

	hold_seen_c: cover property (stop_active ##[1:1000] pos_hold);
	ramp_err_c: cover property (viol ##1 error_stop);
	toff_seen_c: cover property (stop_active ##1 torque_off && !error_stop);

endmodule

// ==== src/csrm_pkg.sv ====
// constants, types and register map of the controlled stop ramp monitor
package csrm_pkg;

	// ====================================================================
	// timing
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned MS_PER_S    = 1000;
	localparam int unsigned CYC_PER_MS  = CLK_HZ / MS_PER_S;
	localparam int unsigned PCT_FULL    = 100;
	localparam int unsigned SMOOTH_DIV  = 200;
	localparam logic [7:0]  ENC_MS_SHORT = 8'h0C;
	localparam logic [7:0]  ENC_MS_MID   = 8'h32;
	localparam logic [7:0]  ENC_MS_LONG  = 8'h64;
	localparam logic [7:0]  PCT_MAX      = 8'h64;

	// ====================================================================
	// register map, byte addresses
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ENC    = 8'h08;
	localparam logic [7:0] OFS_WINDOW = 8'h0C;
	localparam logic [7:0] OFS_INTVL  = 8'h10;
	localparam logic [7:0] OFS_CFG    = 8'h14;
	localparam logic [7:0] OFS_SMOOTH = 8'h18;
	localparam logic [7:0] OFS_REL    = 8'h1C;
	localparam logic [7:0] OFS_ABS    = 8'h20;
	localparam logic [7:0] OFS_MONSPD = 8'h24;
	localparam logic [7:0] OFS_MARGIN = 8'h28;
	localparam int unsigned CTRL_FOLLOW = 0;
	localparam int unsigned CTRL_ACK    = 1;
	localparam int unsigned CFG_SRC     = 0;
	localparam int unsigned CFG_MODE    = 1;
	localparam int unsigned CFG_RAMP    = 2;
	localparam int unsigned CFG_OFSABS  = 3;

	// ====================================================================
	// reset values
	localparam logic [15:0] RST_WINDOW = 16'h000A;
	localparam logic [15:0] RST_INTVL  = 16'h03E8;
	localparam logic [15:0] RST_ABS    = 16'h0000;
	localparam logic [7:0]  RST_SMOOTH = 8'h00;
	localparam logic [7:0]  RST_REL    = 8'h00;
	localparam logic [15:0] MARGIN_TOP = 16'hFFFF;

	// ====================================================================
	// types
	typedef enum logic [2:0] {CSRM_IDLE, CSRM_STOP, CSRM_HOLD, CSRM_TOFF, CSRM_ERROR} csrm_state_t;
	typedef struct packed {
		logic [7:0]  enc_ms;
		logic [15:0] window;
		logic [15:0] interval;
		logic        src;
		logic        mode;
		logic        ramp_en;
		logic        ofs_abs;
		logic [7:0]  smooth;
		logic [7:0]  rel;
		logic [15:0] abs_ofs;
	} csrm_cfg_t;
	typedef struct packed {
		logic        active;
		logic        pos_hold;
		logic        torque_off;
		logic        err;
		logic        zero;
	} csrm_out_t;
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} csrm_apb_t;

endpackage

// ==== tb/csrm_safety_ctrl.sv ====
// safety controller model driving the stop request bit of the safety bus
`timescale 1ns/1ps
module csrm_safety_ctrl
	import csrm_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       req,
	input  wire logic [3:0] dly,
	output logic            stop_bus_bit
);
	logic [3:0] cnt_q;

	// ====================================================================
	// request line
	// plain level request
	// follows the bench command dly+1 cycles later, so prompt and slow answers both occur
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q        <= 4'h0;
			stop_bus_bit <= 1'b0;
		end else if (req == stop_bus_bit) begin
			cnt_q <= 4'h0;
		end else if (cnt_q >= dly) begin
			stop_bus_bit <= req;
			cnt_q        <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule

// ==== tb/csrm_monitor_bench.sv ====
// self-checking bench of the controlled stop ramp monitor
`timescale 1ns/1ps
module csrm_monitor_bench;
	import csrm_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        speed_vld, param_unlock, req, stop_bus_bit, enc_fault;
	logic        torque_off, pos_hold, error_stop, zero_speed, stop_active;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] speed_rpm;
	logic [3:0]  dly;
	int          err_count, check_count, n, v;
	logic [7:0]  ra [8] = '{OFS_ENC, OFS_WINDOW, OFS_INTVL, OFS_CFG,
		OFS_SMOOTH, OFS_REL, OFS_ABS, OFS_MARGIN};
	logic [31:0] rv [8] = '{32'h0000000C, 32'h0000000A, 32'h000003E8, 32'h00000000,
		32'h00000000, 32'h00000000, 32'h00000000, 32'h0000FFFF};

	csrm_monitor #(.CYC_PER_MS_P(10)) u_csrm_monitor (
		.pclk(pclk), .presetn(presetn), .pclken(1'b1), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_bus_bit(stop_bus_bit),
		.param_unlock(param_unlock), .enc_fault(enc_fault), .speed_rpm(speed_rpm),
		.speed_vld(speed_vld), .torque_off(torque_off), .pos_hold(pos_hold),
		.error_stop(error_stop), .zero_speed(zero_speed), .stop_active(stop_active));
	csrm_safety_ctrl u_csrm_safety_ctrl (.pclk(pclk), .presetn(presetn), .req(req),
		.dly(dly), .stop_bus_bit(stop_bus_bit));

	// ====================================================================
	// helpers
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// waits as long as the slave needs, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk("pslverr", {31'h0, er}, {31'h0, e});
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk("prdata", rd, exp);
	endtask
	task automatic spd(input int s);
		@(posedge pclk);
		speed_rpm <= 16'(s); speed_vld <= 1'b1;
		@(posedge pclk);
		speed_vld <= 1'b0;
	endtask
	// waits for pos_hold (0), error_stop (1) or torque_off (2), cycles in n
	task automatic waitfor(input int s);
		logic [2:0] seen;
		n = 0;
		seen = {torque_off, error_stop, pos_hold};
		while (seen[s] !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
			seen = {torque_off, error_stop, pos_hold};
		end
	endtask
	task automatic stop(input logic r);
		@(posedge pclk);
		req <= r; dly <= 4'($urandom_range(0, 6));
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		tally_and_finish;
	end

	// ====================================================================
	// main sequence
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; speed_rpm = 16'h0; speed_vld = 1'b0; param_unlock = 1'b0;
		req = 1'b0; dly = 4'h0; err_count = 0; check_count = 0;
		enc_fault = 1'b0;
		v = $urandom(32'h4a20);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) rreg(ra[i], rv[i]);
		wr(8'h2C, 32'h0, 1'b1);
		wr(OFS_INTVL, 32'h14, 1'b1);
		$display("reset and lock test done");
		param_unlock <= 1'b1;
		repeat (3) @(posedge pclk);
		foreach (rv[i]) if (i < 3) begin
			wr(OFS_ENC, {24'h0, i == 0 ? ENC_MS_SHORT : i == 1 ? ENC_MS_MID : ENC_MS_LONG}, 1'b0);
		end
		wr(OFS_ENC, 32'h0000000D, 1'b1);
		rreg(OFS_ENC, 32'h00000064);
		wr(OFS_INTVL, 32'h14, 1'b0);
		spd(5);
		stop(1'b1);
		repeat (30) @(posedge pclk);
		chk("src off", {31'h0, stop_active}, 32'h0);
		stop(1'b0);
		repeat (15) @(posedge pclk);
		$display("source test done");
		wr(OFS_CFG, 32'h3, 1'b0);
		stop(1'b1);
		waitfor(0);
		chk("mode1 fast", {31'h0, n < 30}, 32'h1);
		rreg(OFS_STATUS, 32'h00000029);
		stop(1'b0);
		repeat (15) @(posedge pclk);
		chk("hold off", {31'h0, pos_hold}, 32'h0);
		$display("hold test done");
		wr(OFS_CTRL, 32'h1, 1'b0);
		wr(OFS_CFG, 32'h1, 1'b0);
		stop(1'b1);
		waitfor(2);
		chk("follow time", {31'h0, n >= 195 && n <= 235}, 32'h1);
		chk("no hold", {30'h0, pos_hold, error_stop}, 32'h0);
		stop(1'b0);
		repeat (15) @(posedge pclk);
		wr(OFS_CTRL, 32'h0, 1'b0);
		$display("follow test done");
		spd(500);
		stop(1'b1);
		waitfor(1);
		chk("error time", {31'h0, n >= 195 && n <= 235}, 32'h1);
		chk("error toff", {31'h0, torque_off}, 32'h1);
		wr(OFS_CTRL, 32'h2, 1'b0);
		stop(1'b0);
		repeat (20) @(posedge pclk);
		chk("sticky", {31'h0, error_stop}, 32'h1);
		wr(OFS_CTRL, 32'h2, 1'b0);
		repeat (3) @(posedge pclk);
		chk("acked", {31'h0, error_stop}, 32'h0);
		$display("error test done");
		spd(100);
		wr(OFS_ABS, 32'h14, 1'b0);
		wr(OFS_CFG, 32'hD, 1'b0);
		stop(1'b1);
		repeat (12) @(posedge pclk);
		chk("ramp early", {31'h0, error_stop}, 32'h0);
		chk("ramp active", {31'h0, stop_active}, 32'h1);
		spd(300);
		waitfor(1);
		chk("ramp trip", {31'h0, n <= 10}, 32'h1);
		apb(1'b0, OFS_MARGIN, 32'h0);
		// margin never above the absolute start offset of 20 rpm
		chk("margin", {31'h0, rd <= 32'h00000014}, 32'h1);
		apb(1'b0, OFS_MONSPD, 32'h0);
		// envelope never above speed 100 plus offset 20
		chk("monitored", {31'h0, rd <= 32'h00000078}, 32'h1);
		stop(1'b0);
		repeat (12) @(posedge pclk);
		wr(OFS_CTRL, 32'h2, 1'b0);
		$display("ramp test done");
		wr(OFS_ENC, 32'h0000000C, 1'b0);
		@(posedge pclk);
		enc_fault <= 1'b1;
		waitfor(1);
		chk("enc time", {31'h0, n >= 110 && n <= 130}, 32'h1);
		chk("enc toff", {31'h0, torque_off}, 32'h1);
		@(posedge pclk);
		enc_fault <= 1'b0;
		repeat (5) @(posedge pclk);
		chk("enc sticky", {31'h0, error_stop}, 32'h1);
		wr(OFS_CTRL, 32'h2, 1'b0);
		repeat (3) @(posedge pclk);
		chk("enc acked", {31'h0, error_stop}, 32'h0);
		$display("encoder fault test done");
		for (int i = 0; i < 24; i++) begin
			v = $urandom_range(0, 25);
			spd(v);
			repeat (2) @(posedge pclk);
			chk("zero", {31'h0, zero_speed}, {31'h0, v <= 10});
		end
		$display("zero speed test done");
		stop(1'b1);
		repeat (12) @(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("reset outs", {27'h0, stop_active, pos_hold, torque_off, error_stop,
			zero_speed}, 32'h1);
		rreg(OFS_CFG, 32'h0);
		repeat (20) @(posedge pclk);
		chk("reset src", {31'h0, stop_active}, 32'h0);
		stop(1'b0);
		$display("mid-run reset test done");
		tally_and_finish;
	end
endmodule
